// ---- design/input_loop_host_mailbox.sv ----
`timescale 1ns/100ps
`default_nettype none
module input_loop_host_mailbox
  import loop_mailbox_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_ack_o,
  input wire logic tick_i,
  input wire logic timer_i,
  input wire logic nmi_i,
  input wire logic nmi_fast_i,
  input wire input_ev_s key_i,
  input wire input_ev_s rotary_i,
  input wire loop_ev_s loop_i,
  input wire timers_s timers_i,
  input wire logic loop_tx_ready_i,
  output loop_tx_s loop_tx_o,
  output setup_s setup_o,
  output logic core_reset_o,
  output logic irq_o,
  output logic nmi_o
);

  typedef struct packed {
    fsm_e fsm;
    logic core_reset;
    logic [31:0] inbox;
    logic last_cmd;
    logic input_full_flag;
    logic output_full_flag;
    logic [3:0] reason;
    logic [7:0] outbox;
    logic nmi_reason;
    logic nmi;
    logic irq;
    logic [4:0] mask;
    logic [7:0] ram_ptr;
    logic [7:0] cmd;
    logic [1:0] left;
    logic [23:0] acc;
    logic [2:0] idx;
    logic wait_rd;
    logic tick_pend;
    logic timer_pend;
    input_ev_s key_pend;
    input_ev_s rot_pend;
    loop_ev_s loop_pend;
    logic loop_hdr_done;
    loop_tx_s tx;
    setup_s setup;
    logic [31:0] rdata;
    logic ack;
    logic ram_we;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
  } state_s;

  localparam state_s RESET_STATE = '{
    fsm: ST_TEST,
    core_reset: 1'b1,
    mask: MASK_RESET,
    default: '0
  };

  state_s s_q;
  state_s s_d;
  logic [7:0] ram_rdata;

  // Low reason bits: both held = 00, control = 01, shift = 10, none = 11.
  function automatic logic [3:0] mod_code(input logic [1:0] hi, input input_ev_s ev);
    mod_code = {hi, ~ev.ctrl, ~ev.shift};
  endfunction

  function automatic logic [1:0] param_len(input logic [7:0] c);
    logic [1:0] n;
    n = 2'd0;
    if (c == CMD_REPEAT_A || c == CMD_REPEAT_B || c == CMD_ROT_RATE || c == CMD_SET_PTR ||
        c[7:4] == CMD_RAMWR_HI) begin
      n = 2'd1;
    end else if (c == CMD_FAST_DLY) begin
      n = 2'd2;
    end else if (c == CMD_MATCH || c == CMD_DELAY || c == CMD_CYCLE) begin
      n = 2'd3;
    end
    param_len = n;
  endfunction

  function automatic logic is_read_cmd(input logic [7:0] c);
    is_read_cmd = (c[7:5] == CMD_READ_LO_HI) || (c[7:4] == CMD_READ_HI_HI);
  endfunction

  always_comb begin
    logic [11:0] idx;
    logic post;
    logic [3:0] post_rsn;
    logic [7:0] post_data;
    logic consume;
    logic [7:0] byte_in;
    idx = reg_addr_i[ADDR_W-1:2];
    post = 1'b0;
    post_rsn = RSN_NONE;
    post_data = 8'h00;
    consume = 1'b0;
    byte_in = s_q.inbox[7:0];
    s_d = s_q;
    s_d.ack = reg_wr_i | reg_rd_i;
    s_d.ram_we = 1'b0;
    s_d.nmi = 1'b0;

    // Event capture runs in every state; an event arriving while its slot is still pending, posting cycle included, is dropped.
    // Mask bit gating
    if (key_i.valid && !s_q.mask[MASK_INPUT] && !s_q.key_pend.valid) begin
      s_d.key_pend = key_i;
    end
    if (rotary_i.valid && !s_q.mask[MASK_INPUT] && !s_q.rot_pend.valid) begin
      s_d.rot_pend = rotary_i;
    end
    if (loop_i.valid && !s_q.mask[MASK_INPUT] && !s_q.loop_pend.valid) begin
      s_d.loop_pend = loop_i;
      s_d.loop_hdr_done = 1'b0;
    end
    if (nmi_i && (nmi_fast_i ? !s_q.mask[MASK_FAST] : !s_q.mask[MASK_RESET_KEY])) begin
      s_d.nmi_reason = nmi_fast_i;
      s_d.nmi = 1'b1;
    end

    unique case (s_q.fsm)
      ST_IDLE: begin
        if (!s_q.output_full_flag && s_q.loop_pend.valid && !s_q.loop_hdr_done) begin
          post = 1'b1;
          post_rsn = RSN_LOOP_HDR;
          post_data = 8'h00;
          post_data[HDR_AP_BIT] = s_q.loop_pend.autopoll;
          post_data[HDR_CMD_BIT] = s_q.loop_pend.is_cmd;
          post_data[2:0] = s_q.loop_pend.addr;
          s_d.loop_hdr_done = 1'b1;
        end else if (!s_q.output_full_flag && s_q.loop_pend.valid) begin
          post = 1'b1;
          post_rsn = RSN_LOOP_DATA;
          post_data = s_q.loop_pend.data;
          s_d.loop_pend.valid = 1'b0;
        end else if (!s_q.output_full_flag && s_q.key_pend.valid) begin
          post = 1'b1;
          post_rsn = mod_code(RSN_KEY_HI, s_q.key_pend);
          post_data = s_q.key_pend.data;
          s_d.key_pend.valid = 1'b0;
        end else if (!s_q.output_full_flag && s_q.rot_pend.valid) begin
          post = 1'b1;
          post_rsn = mod_code(RSN_ROT_HI, s_q.rot_pend);
          post_data = s_q.rot_pend.data;
          s_d.rot_pend.valid = 1'b0;
        end else if (!s_q.output_full_flag && (s_q.tick_pend || s_q.timer_pend)) begin
          post = 1'b1;
          post_rsn = s_q.tick_pend ? (s_q.timer_pend ? RSN_BOTH : RSN_TICK) : RSN_TIMER;
          s_d.tick_pend = 1'b0;
          s_d.timer_pend = 1'b0;
        end else if (s_q.input_full_flag && s_q.last_cmd) begin
          s_d.cmd = byte_in;
          if (is_read_cmd(byte_in)) begin
            if (!s_q.output_full_flag) begin
              consume = 1'b1;
              s_d.ram_addr = (byte_in == 8'h00) ? s_q.ram_ptr : byte_in;
              s_d.fsm = ST_READ;
            end
          end else begin
            consume = 1'b1;
            if (byte_in == CMD_LD_REAL || byte_in == CMD_LD_FAST ||
                byte_in == CMD_LD_DELAY || byte_in == CMD_LD_CYCLE) begin
              s_d.acc = (byte_in == CMD_LD_REAL) ? timers_i.real_time :
                        (byte_in == CMD_LD_FAST) ? timers_i.fast_time :
                        (byte_in == CMD_LD_DELAY) ? timers_i.delay_time :
                        timers_i.cycle_time;
              s_d.idx = 3'd0;
              s_d.fsm = ST_TLOAD;
            end else if (byte_in[7:6] == CMD_MASK_HI) begin
              s_d.mask = byte_in[4:0];
            end else if (param_len(byte_in) != 2'd0) begin
              s_d.left = param_len(byte_in);
              s_d.acc = '0;
              s_d.fsm = ST_PARAM;
            end else if (byte_in == CMD_LOOP_XMIT) begin
              s_d.idx = 3'd0;
              s_d.wait_rd = 1'b0;
              s_d.fsm = ST_XMIT;
            end
          end
        end else if (s_q.input_full_flag) begin
          consume = 1'b1;
        end
      end
      ST_READ: begin
        post = 1'b1;
        post_rsn = RSN_REQ;
        post_data = ram_rdata;
        s_d.fsm = ST_IDLE;
      end
      ST_PARAM: begin
        if (s_q.input_full_flag && s_q.last_cmd) begin
          s_d.fsm = ST_IDLE;
        end else if (s_q.input_full_flag) begin
          consume = 1'b1;
          s_d.acc = {s_q.acc[15:0], byte_in};
          s_d.left = s_q.left - 2'd1;
          if (s_q.left == 2'd1) begin
            s_d.fsm = ST_IDLE;
            unique case (s_q.cmd)
              CMD_REPEAT_A, CMD_REPEAT_B: s_d.setup.repeat_delay = byte_in;
              CMD_ROT_RATE: s_d.setup.rotary_rate = byte_in;
              CMD_FAST_DLY: s_d.setup.fast_hs_delay = {s_q.acc[7:0], byte_in};
              CMD_MATCH: s_d.setup.match_value = {s_q.acc[15:0], byte_in};
              CMD_DELAY: s_d.setup.delay_value = {s_q.acc[15:0], byte_in};
              CMD_CYCLE: s_d.setup.cycle_value = {s_q.acc[15:0], byte_in};
              CMD_SET_PTR: s_d.ram_ptr = byte_in;
              default: begin
                s_d.ram_we = 1'b1;
                s_d.ram_addr = {RAM_HIGH_PAGE, s_q.cmd[3:0]};
                s_d.ram_wdata = byte_in;
              end
            endcase
          end
        end
      end
      ST_TLOAD: begin
        // Low byte first at the buffer base.
        s_d.ram_we = 1'b1;
        s_d.ram_addr = RAM_TBUF_BASE + {5'h00, s_q.idx};
        s_d.ram_wdata = s_q.acc[7:0];
        s_d.acc = {8'h00, s_q.acc[23:8]};
        s_d.idx = s_q.idx + 3'd1;
        if (s_q.idx[1:0] == TBUF_LAST) begin
          s_d.fsm = ST_IDLE;
        end
      end
      ST_XMIT: begin
        if (s_q.tx.valid) begin
          if (loop_tx_ready_i) begin
            s_d.tx.valid = 1'b0;
            s_d.idx = s_q.idx + 3'd1;
            if (s_q.idx == LOOP_BUF_LAST) begin
              s_d.fsm = ST_IDLE;
            end
          end
        end else if (s_q.wait_rd) begin
          s_d.wait_rd = 1'b0;
          s_d.tx.valid = 1'b1;
          s_d.tx.data = ram_rdata;
        end else begin
          s_d.ram_addr = LOOP_BUF_BASE + {5'h00, s_q.idx};
          s_d.wait_rd = 1'b1;
        end
      end
      ST_TEST: begin
        s_d.ram_we = 1'b1;
        s_d.ram_addr = RAM_TEST_ADDR;
        s_d.ram_wdata = RAM_TEST_PASS;
        post = 1'b1;
        post_rsn = RSN_SELFTEST;
        post_data = RAM_TEST_PASS;
        s_d.fsm = ST_IDLE;
      end
      default: s_d.fsm = ST_IDLE;
    endcase

    // Set wins over a post clearing the pending bit.
    if (tick_i && !s_q.mask[MASK_TICK]) begin
      s_d.tick_pend = 1'b1;
    end
    if (timer_i && !s_q.mask[MASK_TIMER]) begin
      s_d.timer_pend = 1'b1;
    end

    if (consume) begin
      s_d.input_full_flag = 1'b0;
    end
    if (reg_rd_i && idx == IDX_DATA) begin
      s_d.output_full_flag = 1'b0;
    end
    if (post) begin
      s_d.output_full_flag = 1'b1;
      s_d.reason = post_rsn;
      s_d.outbox = post_data;
    end

    s_d.rdata = '0;
    if (reg_rd_i) begin
      if (idx == IDX_DATA) begin
        s_d.rdata[7:0] = s_q.outbox;
      end else if (idx == IDX_STATUS_CMD) begin
        s_d.rdata[7:0] = {s_q.reason, s_q.last_cmd, s_q.nmi_reason, s_q.input_full_flag, s_q.output_full_flag};
      end
    end
    if (reg_wr_i) begin
      unique case (idx)
        IDX_RESET_HOLD: s_d.core_reset = 1'b1;
        IDX_RESET_RELEASE: s_d.core_reset = 1'b0;
        IDX_DATA, IDX_STATUS_CMD: begin
          s_d.inbox = reg_wdata_i;
          s_d.last_cmd = (idx == IDX_STATUS_CMD);
          s_d.input_full_flag = 1'b1;
        end
        default: ;
      endcase
    end

    if (s_q.core_reset) begin
      s_d.fsm = ST_TEST;
      s_d.input_full_flag = 1'b0;
      s_d.output_full_flag = 1'b0;
      s_d.reason = RSN_NONE;
      s_d.mask = MASK_RESET;
      s_d.ram_ptr = 8'h00;
      s_d.tick_pend = 1'b0;
      s_d.timer_pend = 1'b0;
      s_d.key_pend.valid = 1'b0;
      s_d.rot_pend.valid = 1'b0;
      s_d.loop_pend.valid = 1'b0;
      s_d.tx.valid = 1'b0;
      s_d.ram_we = 1'b0;
      s_d.nmi = 1'b0;
    end
    s_d.irq = s_d.output_full_flag;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  mailbox_ram u_ram (
    .sys_clk_i(sys_clk_i),
    .we_i(s_d.ram_we),
    .addr_i(s_d.ram_addr),
    .wdata_i(s_d.ram_wdata),
    .rdata_o(ram_rdata)
  );

  assign reg_rdata_o = s_q.rdata;
  assign reg_ack_o = s_q.ack;
  assign loop_tx_o = s_q.tx;
  assign setup_o = s_q.setup;
  assign core_reset_o = s_q.core_reset;
  assign irq_o = s_q.irq;
  assign nmi_o = s_q.nmi;

endmodule // input_loop_host_mailbox
`default_nettype wire

// ---- design/loop_mailbox_pkg.sv ----
// Overview of operation
// - Reset register holds core until release.
// - Reason codes 1-3 report tick and timer.
// - Codes 4-7: requested byte, loop, self-test.
// - Keystroke codes 8-11 encode shift and control.
// - Rotary codes 12-15 use same encoding.
// - Status bit 3 marks last write command.
// - Status bit 2 gives the NMI cause.
// - Host write sets input-full; consumption clears it.
// - Posted byte sets output-full.
// - RAM read commands post byte and interrupt.
// - Timer load commands fill timer buffer.
// - Mask commands load five mask bits.
// - Mask bit assignment; bit 5 written zero.
// - Setup commands take following parameter bytes.
// - Pointer command and high RAM writes.
// - Loop transfer command sends buffer out.
// - Absent clock and beeper commands ignored.
// - Loop header posted before every loop byte.
// - Loop byte posted from poll or command.
// - Word access; unused read bits zero.
// - Passed self-test leaves 0x55 in RAM.
package loop_mailbox_pkg;

  localparam int ADDR_W = 14;
  localparam logic [11:0] IDX_RESET_HOLD = 12'h000;
  localparam logic [11:0] IDX_DATA = 12'h800;
  localparam logic [11:0] IDX_STATUS_CMD = 12'h801;
  localparam logic [11:0] IDX_RESET_RELEASE = 12'hc00;

  localparam logic [3:0] RSN_NONE = 4'h0;
  localparam logic [3:0] RSN_TICK = 4'h1;
  localparam logic [3:0] RSN_TIMER = 4'h2;
  localparam logic [3:0] RSN_BOTH = 4'h3;
  localparam logic [3:0] RSN_REQ = 4'h4;
  localparam logic [3:0] RSN_LOOP_HDR = 4'h5;
  localparam logic [3:0] RSN_LOOP_DATA = 4'h6;
  localparam logic [3:0] RSN_SELFTEST = 4'h7;
  localparam logic [1:0] RSN_KEY_HI = 2'h2;
  localparam logic [1:0] RSN_ROT_HI = 2'h3;

  localparam logic [7:0] CMD_LD_REAL = 8'h31;
  localparam logic [7:0] CMD_LD_FAST = 8'h36;
  localparam logic [7:0] CMD_LD_DELAY = 8'h3b;
  localparam logic [7:0] CMD_LD_CYCLE = 8'h3e;
  localparam logic [7:0] CMD_REPEAT_A = 8'ha0;
  localparam logic [7:0] CMD_REPEAT_B = 8'ha2;
  localparam logic [7:0] CMD_ROT_RATE = 8'ha6;
  localparam logic [7:0] CMD_FAST_DLY = 8'hb2;
  localparam logic [7:0] CMD_MATCH = 8'hb4;
  localparam logic [7:0] CMD_DELAY = 8'hb7;
  localparam logic [7:0] CMD_CYCLE = 8'hba;
  localparam logic [7:0] CMD_SET_PTR = 8'hc1;
  localparam logic [7:0] CMD_LOOP_XMIT = 8'hc5;
  localparam logic [1:0] CMD_MASK_HI = 2'h1;
  localparam logic [2:0] CMD_READ_LO_HI = 3'h0;
  localparam logic [3:0] CMD_READ_HI_HI = 4'hf;
  localparam logic [3:0] CMD_RAMWR_HI = 4'he;

  localparam int MASK_INPUT = 0;
  localparam int MASK_RESET_KEY = 1;
  localparam int MASK_TIMER = 2;
  localparam int MASK_TICK = 3;
  localparam int MASK_FAST = 4;
  localparam logic [4:0] MASK_RESET = 5'h00;

  localparam int HDR_AP_BIT = 4;
  localparam int HDR_CMD_BIT = 3;

  localparam logic [7:0] RAM_TEST_ADDR = 8'h7f;
  localparam logic [7:0] RAM_TEST_PASS = 8'h55;
  localparam logic [7:0] RAM_TBUF_BASE = 8'h13;
  localparam logic [3:0] RAM_HIGH_PAGE = 4'hf;
  localparam logic [7:0] LOOP_BUF_BASE = 8'hf0;
  localparam logic [2:0] LOOP_BUF_LAST = 3'h3;
  localparam logic [1:0] TBUF_LAST = 2'h2;

  typedef struct packed {
    logic valid;
    logic shift;
    logic ctrl;
    logic [7:0] data;
  } input_ev_s;

  typedef struct packed {
    logic valid;
    logic autopoll;
    logic is_cmd;
    logic [2:0] addr;
    logic [7:0] data;
  } loop_ev_s;

  typedef struct packed {
    logic [23:0] real_time;
    logic [23:0] fast_time;
    logic [23:0] delay_time;
    logic [23:0] cycle_time;
  } timers_s;

  typedef struct packed {
    logic [7:0] repeat_delay;
    logic [7:0] rotary_rate;
    logic [15:0] fast_hs_delay;
    logic [23:0] match_value;
    logic [23:0] delay_value;
    logic [23:0] cycle_value;
  } setup_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } loop_tx_s;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_READ = 6'h02,
    ST_PARAM = 6'h04,
    ST_TLOAD = 6'h08,
    ST_XMIT = 6'h10,
    ST_TEST = 6'h20
  } fsm_e;

endpackage

// ---- design/mailbox_ram.sv ----
`timescale 1ns/100ps
`default_nettype none
module mailbox_ram (
  input wire logic sys_clk_i,
  input wire logic we_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:255];

  // Contents are not cleared; firmware areas are written before use.
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule // mailbox_ram
`default_nettype wire

// ---- testbench/input_loop_host_mailbox_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module input_loop_host_mailbox_bench import loop_mailbox_pkg::*;;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic wr, rd, ack, tick = 0, timer = 0, nmi = 0, nmi_fast = 0, tx_ready = 0;
  logic core_rst, irq, nmi_p;
  logic [31:0] wdata, rdata;
  input_ev_s key = '0, rot = '0;
  loop_ev_s lev = '0;
  timers_s timers = '0;
  loop_tx_s tx;
  setup_s setup;
  int errors = 0, n_tests = 0;
  int mem[256];
  always #12.5 sys_clk_i = ~sys_clk_i;
  mailbox_host host (.sys_clk_i(sys_clk_i), .ack_i(ack), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  input_loop_host_mailbox uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_ack_o(ack), .tick_i(tick), .timer_i(timer), .nmi_i(nmi), .nmi_fast_i(nmi_fast),
    .key_i(key), .rotary_i(rot), .loop_i(lev), .timers_i(timers),
    .loop_tx_ready_i(tx_ready), .loop_tx_o(tx), .setup_o(setup), .core_reset_o(core_rst),
    .irq_o(irq), .nmi_o(nmi_p));
  task automatic stop_test();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tout(input string m);
    errors++;
    $display("BAD %0t timeout %s", $time, m);
    stop_test();
  endtask
  task automatic acc(input logic w, input logic [11:0] i, input logic [31:0] d,
                     output logic [31:0] q);
    logic ok;
    host.acc(w, i, d, q, ok);
    if (!ok) tout("ack");
  endtask
  // Host waits for input-full to clear, so the inbox is never overwritten.
  task automatic cmd(input logic [7:0] b, input logic dat);
    logic [31:0] q;
    int n;
    acc(1'b1, dat ? IDX_DATA : IDX_STATUS_CMD, {24'h0, b}, q);
    for (n = 0; n < 20; n++) begin
      acc(1'b0, IDX_STATUS_CMD, 32'h0, q);
      if (q[1] === 1'b0) begin
        chk(q[3], !dat, "last write kind");
        return;
      end
    end
    tout("ibf");
  endtask
  task automatic post(input logic [3:0] r, input int d);
    logic [31:0] q;
    int n;
    for (n = 0; n < 30 && irq !== 1'b1; n++) @(negedge sys_clk_i);
    if (irq !== 1'b1) tout("irq");
    acc(1'b0, IDX_STATUS_CMD, 32'h0, q);
    chk({q[7:4], q[0]}, {r, 1'b1}, "reason");
    acc(1'b0, IDX_DATA, 32'h0, q);
    if (d >= 0) chk(q[7:0], d[7:0], "data");
    repeat (2) @(negedge sys_clk_i);
  endtask
  task automatic quiet();
    repeat (8) @(negedge sys_clk_i);
    chk(irq, 1'b0, "unexpected post");
  endtask
  initial begin
    logic [31:0] q;
    logic [23:0] v;
    int i, j, e;
    logic [7:0] tl[4];
    tl = '{CMD_LD_REAL, CMD_LD_FAST, CMD_LD_DELAY, CMD_LD_CYCLE};
    void'($urandom(90));
    repeat (4) @(negedge sys_clk_i);
    rst_i = 1'b0;
    chk(core_rst, 1'b1, "core held");
    acc(1'b1, IDX_RESET_RELEASE, 32'h0, q);
    chk(core_rst, 1'b0, "core released");
    post(RSN_SELFTEST, RAM_TEST_PASS);
    acc(1'b0, IDX_STATUS_CMD, 32'h0, q);
    chk(q[0], 1'b0, "obf after read");
    cmd(8'h40, 1'b0);
    for (i = 0; i < 4; i++) begin
      e = $urandom;
      mem[8'hf0 + i] = e & 255;
      cmd(8'he0 + i, 1'b0);
      cmd(e[7:0], 1'b1);
    end
    cmd(8'hf0, 1'b0);
    acc(1'b1, IDX_STATUS_CMD, 32'hf1, q);
    acc(1'b0, IDX_STATUS_CMD, 32'h0, q);
    chk(q[3:0], 4'hb, "inbox full");
    post(RSN_REQ, mem[8'hf0]);
    post(RSN_REQ, mem[8'hf1]);
    cmd(CMD_SET_PTR, 1'b0);
    cmd(8'hf2, 1'b1);
    cmd(8'h00, 1'b0);
    post(RSN_REQ, mem[8'hf2]);
    cmd(CMD_SET_PTR, 1'b0);
    cmd(RAM_TEST_ADDR, 1'b1);
    cmd(8'h00, 1'b0);
    post(RSN_REQ, RAM_TEST_PASS);
    for (j = 0; j < 4; j++) begin
      timers = {$urandom, $urandom, $urandom};
      v = timers[95 - 24 * j -: 24];
      cmd(tl[j], 1'b0);
      cmd(8'h13, 1'b0);
      post(RSN_REQ, v[7:0]);
      cmd(8'h15, 1'b0);
      post(RSN_REQ, v[23:16]);
    end
    e = $urandom;
    cmd(CMD_ROT_RATE, 1'b0);
    cmd(e[7:0], 1'b1);
    chk(setup.rotary_rate, e[7:0], "rate");
    cmd(CMD_FAST_DLY, 1'b0);
    cmd(e[15:8], 1'b1);
    cmd(e[7:0], 1'b1);
    chk(setup.fast_hs_delay, e[15:0], "fast delay");
    cmd(CMD_CYCLE, 1'b0);
    for (i = 2; i >= 0; i--) cmd(e[8 * i +: 8], 1'b1);
    chk(setup.cycle_value, e[23:0], "cycle");
    for (j = 0; j < 2; j++) begin
      cmd(j ? CMD_REPEAT_B : CMD_REPEAT_A, 1'b0);
      cmd(e[8 * j + 16 +: 8], 1'b1);
      chk(setup.repeat_delay, e[8 * j + 16 +: 8], "repeat");
      cmd(j ? CMD_DELAY : CMD_MATCH, 1'b0);
      for (i = 2; i >= 0; i--) cmd(e[8 * i + 8 * j +: 8], 1'b1);
      chk(j ? setup.delay_value : setup.match_value, e[8 * j +: 24], "three bytes");
    end
    for (j = 2; j < 5; j++) begin
      cmd(8'hc0 + j, 1'b0);
      quiet();
    end
    for (j = 0; j < 8; j++) begin
      e = $urandom;
      @(negedge sys_clk_i);
      if (j < 4) key = '{1'b1, j[0], j[1], e[7:0]};
      else rot = '{1'b1, j[0], j[1], e[7:0]};
      @(negedge sys_clk_i);
      key.valid = 1'b0;
      rot.valid = 1'b0;
      post({1'b1, j[2], ~j[1], ~j[0]}, e[7:0]);
    end
    for (j = 1; j < 4; j++) begin
      @(negedge sys_clk_i);
      tick = j[0];
      timer = j[1];
      @(negedge sys_clk_i);
      tick = 1'b0;
      timer = 1'b0;
      post(j[3:0], -1);
    end
    cmd(8'h4d, 1'b0);
    @(negedge sys_clk_i);
    key = '{1'b1, 1'b0, 1'b0, 8'h12};
    tick = 1'b1;
    timer = 1'b1;
    @(negedge sys_clk_i);
    key.valid = 1'b0;
    tick = 1'b0;
    timer = 1'b0;
    quiet();
    cmd(8'h40, 1'b0);
    e = $urandom;
    @(negedge sys_clk_i);
    lev = '{1'b1, e[12], e[11], e[10:8], e[7:0]};
    @(negedge sys_clk_i);
    lev.valid = 1'b0;
    post(RSN_LOOP_HDR, {3'h0, e[12:8]});
    post(RSN_LOOP_DATA, e[7:0]);
    for (j = 1; j >= 0; j--) begin
      @(negedge sys_clk_i);
      nmi = 1'b1;
      nmi_fast = j[0];
      @(negedge sys_clk_i);
      nmi = 1'b0;
      chk(nmi_p, 1'b1, "nmi pulse");
      acc(1'b0, IDX_STATUS_CMD, 32'h0, q);
      chk(q[2], j[0], "nmi reason");
    end
    cmd(CMD_LOOP_XMIT, 1'b0);
    for (i = 0; i < 4; i++) begin
      for (j = 0; j < 20 && tx.valid !== 1'b1; j++) @(negedge sys_clk_i);
      if (tx.valid !== 1'b1) tout("tx");
      repeat (2) @(negedge sys_clk_i);
      chk(tx.data, mem[8'hf0 + i], "tx byte");
      tx_ready = 1'b1;
      @(negedge sys_clk_i);
      tx_ready = 1'b0;
    end
    acc(1'b1, IDX_RESET_HOLD, 32'h0, q);
    chk(core_rst, 1'b1, "core held by write");
    acc(1'b1, IDX_DATA, 32'h5a, q);
    acc(1'b0, IDX_STATUS_CMD, 32'h0, q);
    chk(q[1:0], 2'h0, "flags while held");
    acc(1'b1, IDX_RESET_RELEASE, 32'h0, q);
    post(RSN_SELFTEST, RAM_TEST_PASS);
    rst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    chk(core_rst, 1'b1, "held again");
    stop_test();
  end
endmodule // input_loop_host_mailbox_bench
`default_nettype wire

// ---- testbench/mailbox_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module mailbox_host
  import loop_mailbox_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdata_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [31:0] wdata_o
);
  initial begin
    addr_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 32'h0;
  end
  task automatic acc(input logic w, input logic [11:0] idx, input logic [31:0] d,
                     output logic [31:0] q, output logic ok);
    int n;
    @(negedge sys_clk_i);
    addr_o = {idx, 2'h0};
    wr_o = w;
    rd_o = !w;
    wdata_o = d;
    @(negedge sys_clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    ok = 1'b0;
    q = 32'h0;
    for (n = 0; n < 3 && !ok; n++) begin
      if (ack_i === 1'b1) begin
        ok = 1'b1;
        q = rdata_i;
      end else
        @(negedge sys_clk_i);
    end
  endtask
endmodule // mailbox_host
`default_nettype wire

// ---- testbench/mailbox_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module mailbox_sva
  import loop_mailbox_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_ack_o,
  input wire logic nmi_i,
  input wire logic loop_tx_ready_i,
  input wire loop_tx_s loop_tx_o,
  input wire logic core_reset_o,
  input wire logic irq_o,
  input wire logic nmi_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
    else $error("no ack after access");
  a_ack_cause: assert property (reg_ack_o |-> $past(reg_wr_i) || $past(reg_rd_i))
    else $error("ack without access");
  a_rdata_high_zero: assert property (reg_ack_o |-> reg_rdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_rdata_idle: assert property (!reg_ack_o |-> reg_rdata_o == 32'h0)
    else $error("read data outside ack");
  a_core_held: assert property ($fell(rst_i) |-> core_reset_o)
    else $error("core not held after reset");
  a_core_release: assert property ((reg_wr_i && reg_addr_i[13:2] == IDX_RESET_RELEASE) |=>
    !core_reset_o)
    else $error("core not released");
  a_selftest_irq: assert property ($fell(core_reset_o) |-> ##2 irq_o)
    else $error("no self-test interrupt");
  a_nmi_cause: assert property (nmi_o |-> $past(nmi_i))
    else $error("nmi pulse without cause");
  a_tx_hold: assert property ((loop_tx_o.valid && !loop_tx_ready_i) |=>
    loop_tx_o.valid && $stable(loop_tx_o.data))
    else $error("tx byte dropped while stalled");
endmodule // mailbox_sva
bind input_loop_host_mailbox mailbox_sva u_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .nmi_i(nmi_i),
  .loop_tx_ready_i(loop_tx_ready_i), .loop_tx_o(loop_tx_o), .core_reset_o(core_reset_o),
  .irq_o(irq_o), .nmi_o(nmi_o));
`default_nettype wire
